// ==== logic/gpap_pkg.sv ====
package gpap_pkg;
  // ----------------------------------------
  // Register offsets (base words; aliases follow at +4/+8/+C)
  // ----------------------------------------
  localparam logic [11:0] GPAP_DIR_OFS = 12'h000;
  localparam logic [11:0] GPAP_PIN_OFS = 12'h010;
  localparam logic [11:0] GPAP_LAT_OFS = 12'h020;
  localparam logic [11:0] GPAP_ODC_OFS = 12'h030;
  localparam logic [11:0] GPAP_ANS_OFS = 12'h040;
  localparam logic [11:0] GPAP_PUE_OFS = 12'h050;
  localparam logic [11:0] GPAP_CNE_OFS = 12'h060;
  localparam logic [11:0] GPAP_CNF_OFS = 12'h070;
  // ----------------------------------------
  // Alias codes in address bits [3:2]
  // ----------------------------------------
  localparam logic [1:0] GPAP_OP_BASE = 2'h0;
  localparam logic [1:0] GPAP_OP_CLR = 2'h1;
  localparam logic [1:0] GPAP_OP_SET = 2'h2;
  localparam logic [1:0] GPAP_OP_INV = 2'h3;
  // ----------------------------------------
  // Reset values and alias read data
  // ----------------------------------------
  localparam logic [31:0] GPAP_DIR_RST = 32'hFFFFFFFF;
  localparam logic [31:0] GPAP_ANS_RST = 32'h00000000;
  localparam logic [31:0] GPAP_ZERO_RST = 32'h00000000;
  localparam logic [31:0] GPAP_ALIAS_RD = 32'h00000000;
endpackage

// ==== logic/gpap_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
module gpap_sync #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o,
  output logic [W-1:0] q_prev_o
);
  logic [W-1:0] meta_r;
  // ----------------------------------------
  // Two-stage synchroniser plus history stage
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_r <= '0;
      q_o <= '0;
      q_prev_o <= '0;
    end
    else
    begin
      meta_r <= d_i;
      q_o <= meta_r; // [RULE19]
      q_prev_o <= q_o; // [RULE19]
    end
  end
endmodule // gpap_sync
`default_nettype wire

// ==== logic/gpap_top.sv ====
// Behaviour
// [RULE1] Direction bit 1 makes pin input, 0 makes it drive output.
// [RULE2] All direction bits reset to input.
// [RULE3] Analog-capable pins come out of reset in analog mode.
// [RULE4] Pin register reads synchronised pin levels, not the latch.
// [RULE5] Writes to the pin register land in the output latch.
// [RULE6] Latch reads last value written via latch or pin register.
// [RULE7] Unimplemented pin bits of direction, latch, pin read zero.
// [RULE8] Clear/set/invert aliases modify only bits written as 1.
// [RULE9] Aliases sit at base plus 0x4, 0x8, 0xC.
// [RULE10] Alias reads return undefined data; base shows effect.
// [RULE11] Software should toggle outputs via the pin invert alias.
// [RULE12] Analog-select bit 1 makes the pin digital.
// [RULE13] Software sets analog pins to select 0 and direction input.
// [RULE14] Analog pins have digital input disabled, pin bit reads 0.
// [RULE15] Analog-select resets to zero, all capable pins analog.
// [RULE16] Open-drain outputs drive low only and float high.
// [RULE17] Change on a selected notify pin raises interrupt request.
// [RULE18] Pull-up enable bit turns on that pin's weak pull-up.
// [RULE19] Inputs pass two flops; detector compares with previous sample.
// [RULE20] Change flag sticks until software clears; later change resets it. Here a later change sets the flag again, it never clears it.
`timescale 1ns/10ps
`default_nettype none
module gpap_top
  import gpap_pkg::*;
#(
  parameter int NPIN = 16,
  parameter logic [31:0] IMPL_MASK = 32'h0000FFFF,
  parameter logic [31:0] ANALOG_MASK = 32'h000000FF
) (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Pins
  input wire logic [NPIN-1:0] PIN_I,
  output logic [NPIN-1:0] PIN_O,
  output logic [NPIN-1:0] PIN_OE_N_O,
  output logic [NPIN-1:0] PULLUP_EN_O,
  output logic [NPIN-1:0] ANALOG_EN_O,
  // Change notification
  output logic CN_IRQ_O
);
  localparam logic [NPIN-1:0] IMPL = IMPL_MASK[NPIN-1:0];
  localparam logic [NPIN-1:0] ACAP = ANALOG_MASK[NPIN-1:0];

  // ----------------------------------------
  // Alias arithmetic
  // ----------------------------------------
  function automatic logic [NPIN-1:0] apply_op(input logic [1:0] op, input logic [NPIN-1:0] cur,
                                               input logic [NPIN-1:0] wd);
    case (op)
      GPAP_OP_CLR: apply_op = cur & ~wd; // [RULE8]
      GPAP_OP_SET: apply_op = cur | wd; // [RULE8]
      GPAP_OP_INV: apply_op = cur ^ wd; // [RULE8]
      default: apply_op = wd;
    endcase
  endfunction

  logic [NPIN-1:0] dir_r, lat_r, odc_r, ans_r, pue_r, cne_r, cnf_r;
  logic [NPIN-1:0] dir_nxt, lat_nxt, odc_nxt, ans_nxt, pue_nxt, cne_nxt, cnf_nxt;
  logic [NPIN-1:0] pin_s, pin_prev;
  logic [31:0] prdata_nxt;
  logic [NPIN-1:0] pin_o_nxt, oe_n_nxt;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire acc = PSEL_I && PENABLE_I;
  // Commit only at the ready edge, so an alias write is applied exactly once
  wire wr = acc && PWRITE_I && PREADY_O;
  wire [1:0] op = PADDR_I[3:2]; // [RULE9]
  wire [11:0] base = {PADDR_I[11:4], 4'h0};
  wire aligned = PADDR_I[1:0] == 2'h0;
  wire [NPIN-1:0] wd = PWDATA_I[NPIN-1:0];
  wire hit_dir = aligned && base == GPAP_DIR_OFS;
  wire hit_pin = aligned && base == GPAP_PIN_OFS;
  wire hit_lat = aligned && base == GPAP_LAT_OFS;
  wire hit_odc = aligned && base == GPAP_ODC_OFS;
  wire hit_ans = aligned && base == GPAP_ANS_OFS;
  wire hit_pue = aligned && base == GPAP_PUE_OFS;
  wire hit_cne = aligned && base == GPAP_CNE_OFS;
  wire hit_cnf = aligned && base == GPAP_CNF_OFS;
  wire mapped = hit_dir | hit_pin | hit_lat | hit_odc | hit_ans | hit_pue | hit_cne | hit_cnf;

  // ----------------------------------------
  // Input path
  // ----------------------------------------
  gpap_sync #(.W(NPIN)) u_sync (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RST_N_I),
    .d_i(PIN_I),
    .q_o(pin_s),
    .q_prev_o(pin_prev)
  );

  // Analog pins: digital input gated off
  wire [NPIN-1:0] is_analog = ACAP & ~ans_r; // [RULE12]
  wire [NPIN-1:0] pin_dig = pin_s & ~is_analog & IMPL; // [RULE14] [RULE4] [RULE7]
  wire [NPIN-1:0] prev_dig = pin_prev & ~is_analog;
  wire [NPIN-1:0] changed = (pin_dig ^ prev_dig) & cne_r & IMPL; // [RULE19] [RULE17]

  // ----------------------------------------
  // Register next values
  // ----------------------------------------
  assign dir_nxt = (wr && hit_dir) ? apply_op(op, dir_r, wd) & IMPL : dir_r;
  // Pin writes go to the latch, same as latch writes
  assign lat_nxt = (wr && (hit_lat || hit_pin)) ? apply_op(op, lat_r, wd) & IMPL : lat_r; // [RULE5] [RULE6]
  assign odc_nxt = (wr && hit_odc) ? apply_op(op, odc_r, wd) & IMPL : odc_r;
  assign ans_nxt = (wr && hit_ans) ? apply_op(op, ans_r, wd) & IMPL : ans_r;
  assign pue_nxt = (wr && hit_pue) ? apply_op(op, pue_r, wd) & IMPL : pue_r;
  assign cne_nxt = (wr && hit_cne) ? apply_op(op, cne_r, wd) & IMPL : cne_r;
  // A change in the clear cycle wins over the clear
  assign cnf_nxt = ((wr && hit_cnf) ? apply_op(op, cnf_r, wd) : cnf_r) | changed; // [RULE20]

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  function automatic logic [31:0] widen(input logic [NPIN-1:0] v);
    widen = '0;
    widen[NPIN-1:0] = v;
  endfunction

  wire [NPIN-1:0] rd_base = hit_dir ? dir_r & IMPL : hit_pin ? pin_dig : hit_lat ? lat_r : hit_odc ? odc_r :
                            hit_ans ? ans_r : hit_pue ? pue_r : hit_cne ? cne_r : cnf_r; // [RULE7]
  // Alias reads defined here as zero, callers must not rely on it
  assign prdata_nxt = (!mapped || op != GPAP_OP_BASE) ? GPAP_ALIAS_RD : widen(rd_base); // [RULE10]

  // ----------------------------------------
  // Pad drive
  // ----------------------------------------
  // Open-drain: drive low only, float for a 1
  assign pin_o_nxt = lat_r & ~odc_r; // [RULE16]
  assign oe_n_nxt = dir_r | ~IMPL | (odc_r & lat_r); // [RULE1] [RULE16]

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      dir_r <= GPAP_DIR_RST[NPIN-1:0]; // [RULE2]
      lat_r <= '0;
      odc_r <= '0;
      ans_r <= GPAP_ANS_RST[NPIN-1:0]; // [RULE15] [RULE3]
      pue_r <= '0;
      cne_r <= '0;
      cnf_r <= '0;
    end
    else
    begin
      dir_r <= dir_nxt | ~IMPL;
      lat_r <= lat_nxt;
      odc_r <= odc_nxt;
      ans_r <= ans_nxt;
      pue_r <= pue_nxt;
      cne_r <= cne_nxt;
      cnf_r <= cnf_nxt;
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      PRDATA_O <= '0;
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      PIN_O <= '0;
      PIN_OE_N_O <= '1;
      PULLUP_EN_O <= '0;
      ANALOG_EN_O <= ACAP;
      CN_IRQ_O <= 1'b0;
    end
    else
    begin
      // One wait state: ready rises at the end of the first access cycle, drops after
      PREADY_O <= PSEL_I && PENABLE_I && !PREADY_O;
      // Read data stands only in the cycle that ready does
      PRDATA_O <= (PSEL_I && PENABLE_I && !PWRITE_I && !PREADY_O) ? prdata_nxt : '0;
      PSLVERR_O <= PSEL_I && PENABLE_I && !PREADY_O && !mapped;
      PIN_O <= pin_o_nxt;
      PIN_OE_N_O <= oe_n_nxt;
      PULLUP_EN_O <= pue_r & IMPL; // [RULE18]
      ANALOG_EN_O <= is_analog;
      CN_IRQ_O <= |cnf_r; // [RULE17]
    end
  end
endmodule // gpap_top
`default_nettype wire

// ==== verification/gpap_chk.sv ====
`timescale 1ns/10ps
`default_nettype none
module gpap_chk
  import gpap_pkg::*;
#(
  parameter int NPIN = 16,
  parameter logic [31:0] ANALOG_MASK = 32'h000000FF
) (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  // APB
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  // Pins
  input wire logic [NPIN-1:0] PIN_OE_N_O,
  input wire logic [NPIN-1:0] PULLUP_EN_O,
  input wire logic [NPIN-1:0] ANALOG_EN_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);
  wire logic wr_ok = PREADY_O && PSEL_I && PWRITE_I && !PSLVERR_O;
  wire logic rd_pin = PREADY_O && !PWRITE_I && PADDR_I == GPAP_PIN_OFS;
  wire logic [NPIN-1:0] wd = PWDATA_I[NPIN-1:0];
  // Outputs settle one edge after the change, so three edges are allowed
  a_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready held too long");
  a_ready_time: assert property ($rose(PENABLE_I) && PSEL_I |=> PREADY_O)
    else $error("ready late");
  a_read_idle: assert property (!(PREADY_O && !PWRITE_I) |-> PRDATA_O == 32'h0)
    else $error("read data outside read");
  a_upper_zero: assert property (PRDATA_O[31:NPIN] == '0)
    else $error("upper read bits set");
  a_reset_out: assert property ($rose(RST_N_I) |-> PIN_OE_N_O == '1 && ANALOG_EN_O == ANALOG_MASK[NPIN-1:0])
    else $error("bad reset outputs");
  a_dir_float: assert property (wr_ok && PADDR_I == GPAP_DIR_OFS |-> ##3 (PIN_OE_N_O & $past(wd, 3)) == $past(wd, 3))
    else $error("input pin still driven");
  a_pullup_set: assert property (wr_ok && PADDR_I == GPAP_PUE_OFS |-> ##3 PULLUP_EN_O == $past(wd, 3))
    else $error("pull-up mismatch");
  a_analog_sel: assert property (wr_ok && PADDR_I == GPAP_ANS_OFS |-> ##3 ANALOG_EN_O == (ANALOG_MASK[NPIN-1:0] & ~$past(wd, 3)))
    else $error("analog select mismatch");
  a_analog_rd: assert property (rd_pin |-> (PRDATA_O[NPIN-1:0] & ANALOG_EN_O) == '0)
    else $error("analog pin read nonzero");
endmodule // gpap_chk
bind gpap_top gpap_chk #(.NPIN(NPIN), .ANALOG_MASK(ANALOG_MASK)) gpap_chk_i (.CLK_SYS_I(CLK_SYS_I),
  .RST_N_I(RST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
  .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .PIN_OE_N_O(PIN_OE_N_O), .PULLUP_EN_O(PULLUP_EN_O), .ANALOG_EN_O(ANALOG_EN_O));
`default_nettype wire

// ==== verification/gpap_ext.sv ====
`timescale 1ns/10ps
`default_nettype none
module gpap_ext #(
  parameter int NPIN = 16
) (
  // Clock
  input wire logic clk_i,
  // Device side
  input wire logic [NPIN-1:0] drv_i,
  input wire logic [NPIN-1:0] oe_n_i,
  input wire logic [NPIN-1:0] pu_i,
  // Outside driver
  input wire logic [NPIN-1:0] ext_i,
  input wire logic [NPIN-1:0] ext_en_i,
  // Wire level
  output logic [NPIN-1:0] lvl_o
);
  logic [NPIN-1:0] last_r;
  // Undriven pins without pull-up flip every cycle so a stale value never looks valid
  always_comb
  begin
    for (int k = 0; k < NPIN; k++)
    begin
      if (!oe_n_i[k]) lvl_o[k] = drv_i[k];
      else if (ext_en_i[k]) lvl_o[k] = ext_i[k];
      else if (pu_i[k]) lvl_o[k] = 1'b1;
      else lvl_o[k] = ~last_r[k];
    end
  end
  always_ff @(posedge clk_i) last_r <= lvl_o;
endmodule // gpap_ext
`default_nettype wire

// ==== verification/gpap_top_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, x) begin num_checks++; if ((g) !== (x)) begin bad_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, x); end end
module gpap_top_bench;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e, irq, pready, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q, d;
  logic [15:0] ext = 16'hA5C3, ext_en = 16'hFFFF, pin_o, oe_n, pu, analog, lvl;
  logic [15:0] m [8] = '{16'hFFFF, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
  int bad_count = 0, num_checks = 0, seed = 32'h053A, r, op;
  gpap_top gpap_top_i (.CLK_SYS_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .PIN_I(lvl), .PIN_O(pin_o), .PIN_OE_N_O(oe_n), .PULLUP_EN_O(pu),
    .ANALOG_EN_O(analog), .CN_IRQ_O(irq));
  gpap_ext gpap_ext_i (.clk_i(clk), .drv_i(pin_o), .oe_n_i(oe_n), .pu_i(pu), .ext_i(ext),
    .ext_en_i(ext_en), .lvl_o(lvl));
  initial forever #5 clk = ~clk;
  task automatic end_sim();
    if (bad_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rq,
    output logic re);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    if (n >= 50) bad_count++;
  endtask
  // Model: pin register writes land in the latch, pulled-up pins float high
  task automatic mw(input int t, input int o, input logic [15:0] v);
    if (t == 1) t = 2;
    case (o)
      0: m[t] = v;
      1: m[t] = m[t] & ~v;
      2: m[t] = m[t] | v;
      default: m[t] = m[t] ^ v;
    endcase
  endtask
  function automatic logic [15:0] exp_rd(input int t);
    logic [15:0] oen;
    oen = m[0] | (m[3] & m[2]);
    if (t != 1) return m[t];
    return ((~oen & m[2] & ~m[3]) | (oen & (ext | ~ext_en))) & ~(16'h00FF & ~m[4]);
  endfunction
  task automatic rd_chk(input int t);
    apb(1'b0, 12'(t * 16), 32'h0, q, e);
    `CHK(q, {16'h0, exp_rd(t)})
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    end_sim();
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    `CHK({analog, oe_n}, 32'h00FFFFFF)
    for (int t = 0; t < 7; t++) rd_chk(t);
    for (int i = 0; i < 80; i++)
    begin
      r = $unsigned($random(seed)) % 7;
      op = $unsigned($random(seed)) % 4;
      d = $random(seed);
      ext <= 16'($random(seed));
      apb(1'b1, 12'(r * 16 + op * 4), d, q, e);
      mw(r, op, d[15:0]);
      repeat (6) @(posedge clk);
      rd_chk(r);
      rd_chk(1);
    end
    apb(1'b1, 12'h050, 32'hFFFF, q, e);
    mw(5, 0, 16'hFFFF);
    ext_en <= 16'h0000;
    repeat (6) @(posedge clk);
    rd_chk(1);
    ext_en <= 16'hFFFF;
    apb(1'b0, 12'h080, 32'h0, q, e);
    `CHK({e, q}, 33'h100000000)
    apb(1'b1, 12'h048, 32'h1, q, e);
    apb(1'b1, 12'h008, 32'h1, q, e);
    apb(1'b1, 12'h060, 32'h1, q, e);
    repeat (6) @(posedge clk);
    apb(1'b1, 12'h074, 32'hFFFF, q, e);
    repeat (6) @(posedge clk);
    `CHK(irq, 1'b0)
    ext <= ext ^ 16'h0001;
    repeat (8) @(posedge clk);
    `CHK(irq, 1'b1)
    apb(1'b1, 12'h074, 32'h1, q, e);
    repeat (4) @(posedge clk);
    `CHK(irq, 1'b0)
    end_sim();
  end
endmodule // gpap_top_bench
`default_nettype wire
